// ==== core/cbl_config_byte_loader.sv ====
// configuration byte store and reset-time loader into control bits
// ****************************************************************
// Notes on behaviour
// - after reset copy each config bit with a control twin into it
// - software reset reloads config bytes 0 to 2 except boot-block selection
// - four eight-bit config bytes, all ones when unprogrammed
// - byte 0 bit 7 picks boot block: 1 application, 0 loader
// - byte 0 bit 2 low blocks external-code table reads of internal code
// - byte 0 bit 1 low makes programmer reads of code blocks return FFH
// - config bytes readable when locked; locked refuses single erase/program
// - whole-chip erase clears lock by erasing all four config bytes; an ISP-mode erase of byte 0 clears it too
// - lock does not change in-system programming
// - byte 0 bit 0: 1 no data flash, 0 data flash shares 64k
// - byte 1 is data-flash start high byte, used only when enabled
// - start high byte 00H means no internal application, run external
// - byte 2 bit 7 enables brown-out detection
// - byte 2 bits 6:5 pick threshold 2.2V 2.7V 3.8V 4.5V
// - byte 2 bit 4 lets brown-out assert system reset
// - software may change control copies; non-reloading resets keep them
// - boot select control loads inverted config bit except on software reset
// ****************************************************************
`timescale 1ns/1ns
module cbl_config_byte_loader
  import cbl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  // reset request sources
  input  wire logic       por_reset,
  input  wire logic       sw_reset,
  // nonvolatile side: programmer or in-system programming
  input  wire logic       nv_wr,
  input  wire logic       nv_erase,
  input  wire logic       chip_erase,
  input  wire logic       isp_mode,
  input  wire logic [1:0] nv_idx,
  input  wire logic [7:0] nv_wdata,
  output logic      [7:0] nv_rdata,
  output logic            nv_refused,
  // programmer read path of code memory
  input  wire logic [7:0] prog_mem_data,
  output logic      [7:0] prog_read_data,
  // control-bit copies, software side
  input  wire logic       ctl_wr,
  input  wire logic [1:0] ctl_idx,
  input  wire logic [7:0] ctl_wdata,
  output logic      [7:0] ctl_rdata,
  // decoded controls
  output logic            cpu_reset_hold,
  output logic            boot_select_ctl,
  output logic            table_read_restrict,
  output logic            chip_locked,
  output logic            data_flash_present_n,
  output logic      [7:0] data_flash_base_high_copy,
  output logic            no_internal_app,
  output logic            brownout_detect_on,
  output logic      [1:0] brownout_level,
  output logic            brownout_reset_on,
  input  wire logic       brownout_event,
  output logic            brownout_sys_reset
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_n_q;

  // two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q   <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q   <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // nonvolatile configuration bytes
  // ****************************************************************
  // power-up contents start unprogrammed and survive every reset
  logic [7:0] nv_q [CBL_NBYTES] = '{default: CBL_UNPROG};
  logic [7:0] nv_d [CBL_NBYTES];
  logic       refused_q;
  logic       refused_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // reserved positions forced unprogrammed on the stored copy
  function automatic logic [7:0] keep_rsv(logic [1:0] idx, logic [7:0] v);
    logic [7:0] m;
    m = 8'h00;
    if (idx == CBL_IDX_BOOT) begin
      m = CBL_RSV_MASK0;
    end else if (idx == CBL_IDX_BROWN) begin
      m = CBL_RSV_MASK2;
    end
    return v | m;
  endfunction

  // index 3 of the control window is the boot select bit
  function automatic logic is_boot_slot(logic [1:0] idx);
    return idx == CBL_IDX_CLOCK;
  endfunction

  // lock is byte 0 bit 1 low
  assign chip_locked = ~nv_q[CBL_IDX_BOOT][CBL_BIT_LOCK];

  // program, erase and whole-chip erase of the config store
  always_comb begin
    // hold every byte unless a request changes it
    for (int i = 0; i < CBL_NBYTES; i++) begin
      nv_d[i] = nv_q[i];
    end
    refused_d = 1'b0;
    rdata_d   = nv_q[nv_idx];
    // whole-chip erase wins over the lock
    if (chip_erase) begin
      for (int i = 0; i < CBL_NBYTES; i++) begin
        nv_d[i] = CBL_UNPROG;
      end
    end else if ((nv_wr || nv_erase) && chip_locked && !isp_mode) begin
      refused_d = 1'b1;
    end else if (nv_erase) begin
      nv_d[nv_idx] = CBL_UNPROG;
    end else if (nv_wr) begin
      // flash programming only clears bits
      nv_d[nv_idx] = keep_rsv(nv_idx, nv_q[nv_idx] & nv_wdata);
    end
  end

  // storage keeps contents across resets, so no reset here
  always_ff @(posedge clk) begin
    for (int i = 0; i < CBL_NBYTES; i++) begin
      nv_q[i] <= nv_d[i];
    end
    refused_q <= refused_d;
    rdata_q   <= rdata_d;
  end

  // store read data and refusal, both one cycle late
  assign nv_rdata   = rdata_q;
  assign nv_refused = refused_q;

  // ****************************************************************
  // programmer read path of code memory
  // ****************************************************************
  logic [7:0] pread_q;
  logic [7:0] pread_d;

  // locked chip shows all ones to the programmer
  always_comb begin
    pread_d = chip_locked ? CBL_LOCKED_DATA : prog_mem_data;
  end

  // registered read data, all ones until reset ends
  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pread_q <= CBL_LOCKED_DATA;
    end else begin
      pread_q <= pread_d;
    end
  end

  assign prog_read_data = pread_q;

  // ****************************************************************
  // load sequencer and control copies
  // ****************************************************************
  // sequencer state, load counter, copies and boot select
  cbl_state_t st_q;
  cbl_state_t st_d;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       por_seen_q;
  logic       por_seen_d;
  logic [7:0] cp_q [3];
  logic [7:0] cp_d [3];
  logic       bs_q;
  logic       bs_d;
  logic       rst_req;

  // any reset request while running restarts the load
  assign rst_req = por_reset || sw_reset;

  // sequencer: hold cpu in reset until copies are loaded
  always_comb begin
    // hold everything by default
    st_d       = st_q;
    cnt_d      = cnt_q;
    por_seen_d = por_seen_q;
    for (int i = 0; i < 3; i++) begin
      cp_d[i] = cp_q[i];
    end
    bs_d = bs_q;
    case (st_q)
      CBL_ST_RESET: begin
        // first cycle after reset arms the load counter
        st_d  = CBL_ST_LOAD;
        cnt_d = CBL_LOAD_CYCLES;
      end
      CBL_ST_LOAD: begin
        // copy the store into the control bits
        for (int i = 0; i < 3; i++) begin
          cp_d[i] = nv_q[i];
        end
        // boot select reloads only on a full reset
        if (por_seen_q) begin
          bs_d = ~nv_q[CBL_IDX_BOOT][CBL_BIT_BOOT];
        end
        // count down the load cycles
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          st_d       = CBL_ST_RUN;
          por_seen_d = 1'b0;
        end
      end
      CBL_ST_RUN: begin
        // software owns the copies while running
        if (ctl_wr) begin
          if (is_boot_slot(ctl_idx)) begin
            bs_d = ctl_wdata[0];
          end else begin
            cp_d[ctl_idx] = ctl_wdata;
          end
        end
        // only a full reset request reloads boot select
        if (rst_req) begin
          st_d       = CBL_ST_LOAD;
          cnt_d      = CBL_LOAD_CYCLES;
          por_seen_d = por_reset;
        end
      end
      default: begin
        st_d = CBL_ST_RESET;
      end
    endcase
  end

  // a pin reset counts as a full reset that also reloads boot select
  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      st_q       <= CBL_ST_RESET;
      cnt_q      <= 2'h0;
      por_seen_q <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        cp_q[i] <= CBL_UNPROG;
      end
      bs_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      por_seen_q <= por_seen_d;
      for (int i = 0; i < 3; i++) begin
        cp_q[i] <= cp_d[i];
      end
      bs_q <= bs_d;
    end
  end

  // software read of copies; index 3 shows boot select
  always_comb begin
    ctl_rdata = 8'h00;
    if (is_boot_slot(ctl_idx)) begin
      ctl_rdata = {7'h00, bs_q};
    end else begin
      ctl_rdata = cp_q[ctl_idx];
    end
  end

  // ****************************************************************
  // decoded controls from the copies
  // ****************************************************************
  // cpu held while the copies load; boot select from its own bit
  assign cpu_reset_hold       = (st_q != CBL_ST_RUN);
  assign boot_select_ctl      = bs_q;

  // security and data-flash controls from copy 0
  assign table_read_restrict  = ~cp_q[0][CBL_BIT_TBLRD];
  assign data_flash_present_n = cp_q[0][CBL_BIT_DFN];
  // base is meaningful only with data flash present
  assign data_flash_base_high_copy =
    cp_q[0][CBL_BIT_DFN] ? CBL_UNPROG : cp_q[1];

  // no application space when the data flash starts at zero
  assign no_internal_app      = ~cp_q[0][CBL_BIT_DFN] &&
                                (cp_q[1] == CBL_BASE_NONE);

  // brown-out detection, level and reset enable from copy 2
  assign brownout_detect_on   = cp_q[2][CBL_BIT_BOD_ON];
  assign brownout_level = {cp_q[2][CBL_BIT_LVL_HI],
                           cp_q[2][CBL_BIT_LVL_LO]};
  assign brownout_reset_on    = cp_q[2][CBL_BIT_BOD_RST];
  // a brown-out resets the system only when both enables are set
  assign brownout_sys_reset   = brownout_event && brownout_detect_on &&
                                brownout_reset_on;

endmodule // cbl_config_byte_loader

// ==== core/cbl_pkg.sv ====
// package of constants for the configuration byte loader
package cbl_pkg;
  localparam logic [7:0] CBL_UNPROG       = 8'hFF;
  localparam int         CBL_NBYTES       = 4;
  localparam logic [1:0] CBL_IDX_BOOT     = 2'h0;
  localparam logic [1:0] CBL_IDX_DFBASE   = 2'h1;
  localparam logic [1:0] CBL_IDX_BROWN    = 2'h2;
  localparam logic [1:0] CBL_IDX_CLOCK    = 2'h3;
  localparam int         CBL_BIT_BOOT     = 7;
  localparam int         CBL_BIT_TBLRD    = 2;
  localparam int         CBL_BIT_LOCK     = 1;
  localparam int         CBL_BIT_DFN      = 0;
  localparam int         CBL_BIT_BOD_ON   = 7;
  localparam int         CBL_BIT_LVL_HI   = 6;
  localparam int         CBL_BIT_LVL_LO   = 5;
  localparam int         CBL_BIT_BOD_RST  = 4;
  localparam logic [7:0] CBL_RSV_MASK0    = 8'h78;
  localparam logic [7:0] CBL_RSV_MASK2    = 8'h0F;
  localparam logic [7:0] CBL_BASE_NONE    = 8'h00;
  localparam logic [7:0] CBL_LOCKED_DATA  = 8'hFF;
  localparam logic [1:0] CBL_LOAD_CYCLES  = 2'h2;
  typedef enum logic [1:0] {
    CBL_ST_RESET = 2'b00,
    CBL_ST_LOAD  = 2'b01,
    CBL_ST_RUN   = 2'b11
  } cbl_state_t;
endpackage

// ==== verif/cbl_chk.sv ====
// port assertions for the configuration byte loader
`timescale 1ns/1ns
module cbl_chk
  import cbl_pkg::*;
(
  input wire logic       clk, rstn, por_reset, sw_reset, nv_wr, nv_erase,
  input wire logic       chip_erase, isp_mode, nv_refused, ctl_wr,
  input wire logic       cpu_reset_hold, boot_select_ctl, chip_locked,
  input wire logic       data_flash_present_n, no_internal_app,
  input wire logic       brownout_detect_on, brownout_reset_on,
  input wire logic       brownout_event, brownout_sys_reset,
  input wire logic [1:0] ctl_idx, brownout_level,
  input wire logic [7:0] ctl_wdata, prog_mem_data, prog_read_data,
  input wire logic [7:0] data_flash_base_high_copy
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_bod;
    brownout_sys_reset == (brownout_event && brownout_detect_on
                           && brownout_reset_on);
  endproperty
  a_bod: assert property (p_bod) else $error("bad brownout reset");
  property p_prd;
    !cpu_reset_hold |-> prog_read_data == ($past(chip_locked) ?
      CBL_LOCKED_DATA : $past(prog_mem_data));
  endproperty
  a_prd: assert property (p_prd) else $error("bad prog read");
  property p_ref;
    (nv_wr || nv_erase) && chip_locked && !isp_mode && !chip_erase
      |=> nv_refused;
  endproperty
  a_ref: assert property (p_ref) else $error("not refused");
  property p_isp;
    (nv_wr || nv_erase) && isp_mode |=> !nv_refused;
  endproperty
  a_isp: assert property (p_isp) else $error("isp refused");
  property p_wipe;
    chip_erase |=> !chip_locked;
  endproperty
  a_wipe: assert property (p_wipe) else $error("lock kept");
  property p_load;
    (sw_reset || por_reset) && !cpu_reset_hold
      |=> cpu_reset_hold [*2] ##1 !cpu_reset_hold;
  endproperty
  a_load: assert property (p_load) else $error("bad load length");
  property p_keep;
    sw_reset && !por_reset && !ctl_wr && !cpu_reset_hold
      |-> ##3 boot_select_ctl == $past(boot_select_ctl, 3);
  endproperty
  a_keep: assert property (p_keep) else $error("boot lost");
  property p_dfb;
    data_flash_present_n |-> data_flash_base_high_copy == CBL_UNPROG;
  endproperty
  a_dfb: assert property (p_dfb) else $error("bad base copy");
  property p_app;
    no_internal_app == (!data_flash_present_n
      && data_flash_base_high_copy == CBL_BASE_NONE);
  endproperty
  a_app: assert property (p_app) else $error("bad no app");
  property p_cw;
    ctl_wr && !cpu_reset_hold && ctl_idx == CBL_IDX_BROWN && !sw_reset
      |=> {4'h0, brownout_detect_on, brownout_level, brownout_reset_on}
          == ($past(ctl_wdata) >> 4);
  endproperty
  a_cw: assert property (p_cw) else $error("bad brown copy");
  c_sw: cover property (sw_reset && !cpu_reset_hold);
  c_lock: cover property (chip_locked && nv_refused);
  c_bod: cover property (brownout_sys_reset);
endmodule // cbl_chk
bind cbl_config_byte_loader cbl_chk u_chk (.*);

// ==== verif/cbl_prog_model.sv ====
// programmer model driving the nonvolatile store port
`timescale 1ns/1ns
module cbl_prog_model
  import cbl_pkg::*;
(
  input wire logic  clk,
  output logic       nv_wr, nv_erase, chip_erase, isp_mode,
  output logic [1:0] nv_idx,
  output logic [7:0] nv_wdata
);
  // ********
  // requests
  // ********
  initial begin
    {nv_wr, nv_erase, chip_erase, isp_mode} = 4'h0;
    nv_idx = 2'h0;
    nv_wdata = 8'h00;
  end
  // one request held over one taking edge, op is {wr, erase, chip}
  task automatic pulse(logic [2:0] op, logic [1:0] i, logic [7:0] d,
                       logic isp);
    {nv_wr, nv_erase, chip_erase} = op;
    nv_idx = i;
    isp_mode = isp;
    nv_wdata = d | (i == CBL_IDX_BOOT ? CBL_RSV_MASK0 :
      i == CBL_IDX_BROWN ? CBL_RSV_MASK2 : 8'h00);
    @(posedge clk);
    #5;
    {nv_wr, nv_erase, chip_erase, isp_mode} = 4'h0;
    nv_wdata = ~nv_wdata; // released data shows no stale value
    // one idle edge keeps back-to-back requests apart
    @(posedge clk);
    #5;
  endtask
  task automatic sel(logic [1:0] i);
    nv_idx = i;
  endtask
endmodule // cbl_prog_model

// ==== verif/tb.sv ====
// self-checking bench for the configuration byte loader
`timescale 1ns/1ns
module tb;
  import cbl_pkg::*;
  typedef struct {int sel; logic [9:0] v; int due;} cbl_note_t;
  logic clk = 0, rstn = 0, por_reset = 0, sw_reset = 0, ctl_wr = 0;
  logic brownout_event = 0, nv_wr, nv_erase, chip_erase, isp_mode;
  logic [1:0] ctl_idx = 0, nv_idx, brownout_level;
  logic [7:0] ctl_wdata = 0, prog_mem_data = 0, nv_wdata, nv_rdata, r;
  logic [7:0] prog_read_data, ctl_rdata, data_flash_base_high_copy;
  logic nv_refused, cpu_reset_hold, boot_select_ctl, table_read_restrict;
  logic chip_locked, data_flash_present_n, no_internal_app;
  logic brownout_detect_on, brownout_reset_on, brownout_sys_reset;
  int miscompares = 0, num_checks = 0, cyc = 0, seed = 32'hF126D74D;
  cbl_note_t notes[$];
  string names[6] = '{"status", "nv_rdata", "prog_rd", "ctl_rdata", "ref",
    "dfbase"};
  cbl_config_byte_loader u_dut (.*);
  cbl_prog_model u_prog (.*);
  // ********
  // helpers
  // ********
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [9:0] obs(int s);
    case (s)
      0: return {boot_select_ctl, table_read_restrict, chip_locked,
        data_flash_present_n, no_internal_app, brownout_detect_on,
        brownout_level, brownout_reset_on, brownout_sys_reset};
      1: return {2'h0, nv_rdata};
      2: return {2'h0, prog_read_data};
      3: return {2'h0, ctl_rdata};
      4: return {9'h0, nv_refused};
      default: return {2'h0, data_flash_base_high_copy};
    endcase
  endfunction
  function automatic logic [9:0] st(logic bs, logic [7:0] b0, b1, b2);
    return {bs, ~b0[CBL_BIT_TBLRD], ~b0[CBL_BIT_LOCK], b0[CBL_BIT_DFN],
      ~b0[CBL_BIT_DFN] && b1 == CBL_BASE_NONE, b2[7:4], 1'b0};
  endfunction
  task automatic check(string nm, logic [9:0] seen, logic [9:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (notes.size() > 0) miscompares++;
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic note(int s, logic [9:0] v, int n);
    notes.push_back('{s, v, cyc + n});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic run_wait();
    int k;
    k = 0;
    do begin
      tick(1);
      k++;
    end while (cpu_reset_hold !== 1'b0 && k < 20);
    if (k >= 20) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic req(logic sw);
    sw_reset = sw;
    por_reset = ~sw;
    tick(1);
    {sw_reset, por_reset} = 2'h0;
    run_wait();
  endtask
  task automatic ctl(logic [1:0] i, logic [7:0] d);
    {ctl_wr, ctl_idx, ctl_wdata} = {1'b1, i, d};
    tick(1);
    ctl_wr = 0;
    tick(1);
  endtask
  task automatic rd(logic [1:0] i, logic [7:0] v);
    u_prog.sel(i);
    note(1, {2'h0, v}, 1);
    tick(1);
  endtask
  // compare the oldest due notes against the outputs
  always @(posedge clk) begin
    #2;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      check(names[notes[0].sel], obs(notes[0].sel), notes[0].v);
      void'(notes.pop_front());
    end
  end
  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
  // ********
  // sequence
  // ********
  initial begin
    tick(4);
    rstn = 1;
    run_wait();
    note(0, st(1'b0, 8'hFF, 8'hFF, 8'hFF), 1);
    note(5, 10'h0FF, 1);
    for (int i = 0; i < 3; i++) begin
      ctl_idx = i[1:0];
      note(3, 10'h0FF, 1);
      tick(1);
    end
    u_prog.pulse(3'h4, 2'h0, 8'h02, 1'b0);
    u_prog.pulse(3'h4, 2'h1, 8'h00, 1'b0);
    u_prog.pulse(3'h4, 2'h2, 8'h50, 1'b0);
    rd(2'h0, 8'h7A);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h5F);
    rd(2'h3, 8'hFF);
    ctl(2'h3, 8'h01);
    r = 8'($random(seed));
    ctl(2'h2, r);
    note(3, {2'h0, r}, 1);
    tick(1);
    ctl(2'h2, 8'h90);
    brownout_event = 1;
    note(0, st(1'b1, 8'hFF, 8'hFF, 8'h90) | 10'h1, 1);
    tick(1);
    brownout_event = 0;
    ctl(2'h3, 8'h00);
    req(1'b1);
    note(0, st(1'b0, 8'h7A, 8'h00, 8'h5F), 1);
    note(5, 10'h000, 1);
    tick(1);
    ctl(2'h3, 8'h00);
    req(1'b0);
    note(0, st(1'b1, 8'h7A, 8'h00, 8'h5F), 1);
    tick(1);
    for (int l = 0; l < 4; l++) begin
      ctl(2'h2, {1'b1, l[1:0], 5'h10});
      note(0, st(1'b1, 8'h7A, 8'h00, {1'b1, l[1:0], 5'h10}), 1);
      tick(1);
    end
    u_prog.pulse(3'h4, 2'h0, 8'hFD, 1'b0);
    prog_mem_data = 8'($random(seed));
    note(2, 10'h0FF, 1);
    rd(2'h0, 8'h78);
    note(4, 10'h1, 1);
    u_prog.pulse(3'h2, 2'h1, 8'h00, 1'b0);
    rd(2'h1, 8'h00);
    note(4, 10'h0, 1);
    u_prog.pulse(3'h2, 2'h1, 8'h00, 1'b1);
    rd(2'h1, 8'hFF);
    u_prog.pulse(3'h1, 2'h0, 8'h00, 1'b0);
    r = 8'($random(seed));
    prog_mem_data = r;
    note(2, {2'h0, r}, 1);
    for (int i = 0; i < 3; i++) rd(i[1:0], 8'hFF);
    tick(2);
    finish_test();
  end
endmodule // tb
